// File: design/mvx_exec.sv
`timescale 1ns/100ps

// What this block does
// RULE1 - file-to-destination move: d=0 to working register, d=1 back to file
// RULE2 - 256-byte bank addressing; a=0 access bank, a=1 bank select register
// RULE3 - file-to-destination move sets only N and Z, one cycle, write in Q4
// RULE4 - file-to-file move takes 12-bit addresses, changes no flags
// RULE5 - file-to-file move: source prefix word, then continuation prefix word
// RULE6 - two or three cycles; source read first; second cycle writes in Q4
// RULE7 - working register may be source or destination of file-to-file move
// RULE8 - software must not target counter low or stack top bytes
// RULE9 - bank literal load decoded from fixed upper byte, one cycle
// RULE10 - bank literal load writes full literal in Q4, flags untouched
// RULE11 - working literal load, prefix 0000 1110, one cycle, no flags
module mvx_exec
	import mvx_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic fetch_valid,
	input wire logic [15:0] fetch_word,
	output logic fetch_ready,
	input wire logic [7:0] mem_rd_data,
	output mvx_mem_t mem,
	output logic [7:0] working_reg,
	output logic [7:0] bank_select_reg,
	output logic flag_n,
	output logic flag_z,
	output logic bad_op
);
	mvx_q_t q;
	mvx_state_t s;
	mvx_state_t next_s;
	logic taken;
	logic [11:0] file_addr;

	mvx_quarter u_quarter (
		.clock(clock),
		.rst(rst),
		.q(q)
	);

	// words are only taken at the decode phase of a cycle
	assign fetch_ready = q.q1 && (s.st == ST_IDLE || s.st == ST_WAIT2);
	assign taken = fetch_ready && fetch_valid;

	always_comb begin
		if (fetch_word[8]) begin
			file_addr = {s.bank[3:0], fetch_word[7:0]}; // RULE2
		end else if (fetch_word[7]) begin
			file_addr = {ACCESS_HI_BANK, fetch_word[7:0]}; // RULE2
		end else begin
			file_addr = {4'h0, fetch_word[7:0]}; // RULE2
		end
	end

	always_comb begin
		next_s = s;
		next_s.bad_op = 1'b0;
		next_s.mem.rd_en = 1'b0;
		next_s.mem.wr_en = 1'b0;
		if (taken && s.st == ST_IDLE) begin
			next_s.word = fetch_word;
			next_s.st = ST_EXEC;
			if (fetch_word[15:10] == PFX_FILE_DEST) begin
				next_s.op = OP_FILE_DEST; // RULE1
				next_s.mem.addr = file_addr;
			end else if (fetch_word[15:12] == PFX_FILE_FILE) begin
				next_s.op = OP_FILE_FILE; // RULE5
				next_s.mem.addr = fetch_word[11:0]; // RULE4
			end else if (fetch_word[15:8] == PFX_BANK_LIT) begin
				next_s.op = OP_BANK_LIT; // RULE9
			end else if (fetch_word[15:8] == PFX_WORK_LIT) begin
				next_s.op = OP_WORK_LIT; // RULE11
			end else begin
				// not ours: other decoders own it
				next_s.op = OP_NONE;
				next_s.st = ST_IDLE;
				next_s.bad_op = 1'b1;
			end
		end else if (taken) begin
			// a second word without the continuation prefix aborts the move
			if (fetch_word[15:12] == PFX_CONT) begin
				next_s.st = ST_DEST; // RULE5
				next_s.mem.addr = fetch_word[11:0]; // RULE4
			end else begin
				next_s.st = ST_IDLE;
				next_s.bad_op = 1'b1;
			end
		end else if (s.st == ST_EXEC) begin
			if (q.q2 && (s.op == OP_FILE_DEST || s.op == OP_FILE_FILE)) begin
				// the working register is read locally, not from memory
				next_s.mem.rd_en = (s.mem.addr != WORK_ADDR); // RULE6 RULE7
			end
			if (q.q3) begin
				next_s.data = (s.mem.addr == WORK_ADDR) ? s.work : mem_rd_data;
			end
			if (q.q4) begin
				next_s.st = ST_IDLE;
				case (s.op)
				OP_FILE_DEST: begin
					next_s.neg = s.data[7]; // RULE3
					next_s.zero = (s.data == 8'h00); // RULE3
					if (!s.word[9] || s.mem.addr == WORK_ADDR) begin
						next_s.work = s.data; // RULE1
					end else begin
						next_s.mem.wr_en = 1'b1; // RULE1
						next_s.mem.wr_data = s.data;
					end
				end
				OP_FILE_FILE: begin
					next_s.st = ST_WAIT2; // RULE6
				end
				OP_BANK_LIT: begin
					next_s.bank = s.word[7:0]; // RULE10
				end
				OP_WORK_LIT: begin
					next_s.work = s.word[7:0]; // RULE11
				end
				default: begin
					next_s.st = ST_IDLE;
				end
				endcase
			end
		end else if (s.st == ST_DEST && q.q4) begin
			// no dummy read here; destination legality is software's burden
			next_s.st = ST_IDLE;
			if (s.mem.addr == WORK_ADDR) begin
				next_s.work = s.data; // RULE7
			end else begin
				next_s.mem.wr_en = 1'b1; // RULE6 RULE8
				next_s.mem.wr_data = s.data;
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s <= '{st: ST_IDLE, op: OP_NONE, word: 16'h0000, data: 8'h00,
				work: WORK_RST, bank: BANK_RST, neg: 1'b0, zero: 1'b0,
				bad_op: 1'b0, mem: '{addr: 12'h000, rd_en: 1'b0,
				wr_en: 1'b0, wr_data: 8'h00}};
		end else begin
			s <= next_s;
		end
	end

	assign mem = s.mem;
	assign working_reg = s.work;
	assign bank_select_reg = s.bank;
	assign flag_n = s.neg;
	assign flag_z = s.zero;
	assign bad_op = s.bad_op;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	sequence fd_q4;
		s.st == ST_EXEC && s.op == OP_FILE_DEST && q.q4;
	endsequence

	sequence ff_taken;
		taken && s.st == ST_IDLE && fetch_word[15:12] == PFX_FILE_FILE;
	endsequence

	sequence ff_cont;
		taken && s.st == ST_WAIT2 && fetch_word[15:12] == PFX_CONT;
	endsequence

	AST_FD_WORK: assert property (fd_q4 and !s.word[9] |=> // RULE1
		working_reg == $past(s.data))
		else $error("move to working register lost");
	AST_FD_BACK: assert property (fd_q4 and s.word[9] and // RULE1
		s.mem.addr != WORK_ADDR |=> mem.wr_en && mem.wr_data == $past(s.data))
		else $error("write back to file missing");
	AST_BANKED: assert property (taken && s.st == ST_IDLE && // RULE2
		fetch_word[15:10] == PFX_FILE_DEST && fetch_word[8] |=>
		mem.addr == {bank_select_reg[3:0], $past(fetch_word[7:0])})
		else $error("banked address wrong");
	AST_FLAGS: assert property (fd_q4 |=> // RULE3
		flag_z == ($past(s.data) == 8'h00) && flag_n == $past(s.data[7]))
		else $error("flags do not follow moved value");
	AST_NO_FLAGS: assert property (s.op != OP_FILE_DEST |=> // RULE4
		$stable(flag_n) && $stable(flag_z))
		else $error("flags changed by flag-free move");
	AST_FF_READ: assert property (ff_taken and // RULE6
		fetch_word[11:0] != WORK_ADDR |-> ##2 mem.rd_en)
		else $error("source not read in first cycle");
	AST_FF_WRITE: assert property (ff_cont and // RULE6
		fetch_word[11:0] != WORK_ADDR |-> !mem.rd_en [*4] ##1 mem.wr_en)
		else $error("destination write not at Q4");
	AST_CONT: assert property (taken && s.st == ST_WAIT2 && // RULE5
		fetch_word[15:12] != PFX_CONT |=> bad_op && s.st == ST_IDLE)
		else $error("bad second word accepted");
	AST_BANK_LIT: assert property (s.st == ST_EXEC && // RULE10
		s.op == OP_BANK_LIT && q.q4 |=> bank_select_reg == $past(s.word[7:0]))
		else $error("bank literal not loaded");
	AST_WORK_LIT: assert property (taken && s.st == ST_IDLE && // RULE11
		fetch_word[15:8] == PFX_WORK_LIT |-> ##4
		working_reg == $past(fetch_word[7:0], 4))
		else $error("working literal not loaded");
	AST_ACCESS: assert property (taken && s.st == ST_IDLE && // RULE2
		fetch_word[15:10] == PFX_FILE_DEST && !fetch_word[8] |=>
		mem.addr[7:0] == $past(fetch_word[7:0]) &&
		mem.addr[11:8] == ($past(fetch_word[7]) ? ACCESS_HI_BANK : 4'h0))
		else $error("access bank address wrong");
	AST_FF_TO_WORK: assert property (s.st == ST_DEST && q.q4 && // RULE7
		s.mem.addr == WORK_ADDR |=> working_reg == $past(s.data) && !mem.wr_en)
		else $error("move into working register lost");
	AST_FOREIGN: assert property (taken && s.st == ST_IDLE && // RULE9
		fetch_word[15:10] != PFX_FILE_DEST &&
		fetch_word[15:12] != PFX_FILE_FILE &&
		fetch_word[15:8] != PFX_BANK_LIT &&
		fetch_word[15:8] != PFX_WORK_LIT |=> bad_op && s.st == ST_IDLE)
		else $error("foreign word not refused");

	// single-word moves must hand the next decode slot back at once
	sequence one_word_taken;
		taken && s.st == ST_IDLE && (fetch_word[15:8] == PFX_BANK_LIT ||
			fetch_word[15:8] == PFX_WORK_LIT ||
			fetch_word[15:10] == PFX_FILE_DEST);
	endsequence

	AST_ONE_CYCLE: assert property (one_word_taken |=> // RULE3 RULE9
		!fetch_ready [*3] ##1 fetch_ready)
		else $error("single-word move not done in one cycle");
endmodule : mvx_exec

// File: design/mvx_quarter.sv
`timescale 1ns/100ps

package mvx_pkg;
	// instruction word prefixes
	localparam logic [5:0] PFX_FILE_DEST = 6'h14;
	localparam logic [3:0] PFX_FILE_FILE = 4'hc;
	localparam logic [3:0] PFX_CONT = 4'hf;
	localparam logic [7:0] PFX_BANK_LIT = 8'h01;
	localparam logic [7:0] PFX_WORK_LIT = 8'h0e;
	// data space address at which the working register is mapped
	localparam logic [11:0] WORK_ADDR = 12'hfe8;
	// upper half of the access bank maps to the top of the data space
	localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
	localparam logic [7:0] WORK_RST = 8'h00;
	localparam logic [7:0] BANK_RST = 8'h00;
	localparam logic [1:0] QPH_RST = 2'h0;
	localparam logic [1:0] QPH_LAST = 2'h3;

	typedef struct packed {
		logic q1;
		logic q2;
		logic q3;
		logic q4;
	} mvx_q_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_EXEC = 2'b01,
		ST_WAIT2 = 2'b11,
		ST_DEST = 2'b10
	} mvx_st_t;

	typedef enum logic [2:0] {
		OP_NONE,
		OP_FILE_DEST,
		OP_FILE_FILE,
		OP_BANK_LIT,
		OP_WORK_LIT
	} mvx_op_t;

	typedef struct packed {
		logic [11:0] addr;
		logic rd_en;
		logic wr_en;
		logic [7:0] wr_data;
	} mvx_mem_t;

	typedef struct packed {
		mvx_st_t st;
		mvx_op_t op;
		logic [15:0] word;
		logic [7:0] data;
		logic [7:0] work;
		logic [7:0] bank;
		logic neg;
		logic zero;
		logic bad_op;
		mvx_mem_t mem;
	} mvx_state_t;

	typedef struct packed {
		logic [1:0] ph;
		mvx_q_t q;
	} mvx_qstate_t;
endpackage : mvx_pkg

module mvx_quarter
	import mvx_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	output mvx_q_t q
);
	mvx_qstate_t s;
	mvx_qstate_t next_s;

	// q holds the phase that the coming edge completes
	always_comb begin
		next_s = s;
		next_s.ph = s.ph + 2'h1;
		next_s.q = '{q1: next_s.ph == 2'h0, q2: next_s.ph == 2'h1,
			q3: next_s.ph == 2'h2, q4: next_s.ph == QPH_LAST};
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s <= '{ph: QPH_RST, q: '{q1: 1'b1, q2: 1'b0, q3: 1'b0, q4: 1'b0}};
		end else begin
			s <= next_s;
		end
	end

	assign q = s.q;

	AST_ONE_HOT: assert property ( // RULE3
		@(posedge clock) disable iff (rst) $onehot(q))
		else $error("quarter phases not one-hot");
	AST_PHASE_ORDER: assert property ( // RULE6
		@(posedge clock) disable iff (rst) q.q4 |=> q.q1)
		else $error("quarter phases out of order");
endmodule : mvx_quarter

// File: test/tb_mvx_exec.sv
`timescale 1ns/100ps
module tb_mvx_exec
	import mvx_pkg::*;
;
	logic clock = 0;
	logic rst = 1;
	logic fetch_valid = 0;
	logic [15:0] fetch_word = 16'h0000;
	logic fetch_ready;
	logic [7:0] mem_rd_data;
	mvx_mem_t mem;
	logic [7:0] working_reg;
	logic [7:0] bank_select_reg;
	logic flag_n;
	logic flag_z;
	logic bad_op;
	logic [7:0] dmem [4096];
	logic [11:0] wa;
	logic [7:0] wd;
	int n_mismatch = 0;
	int checks = 0;
	int n_rd = 0;
	int n_wr = 0;

	mvx_exec u_mvx_exec (.clock(clock), .rst(rst),
		.fetch_valid(fetch_valid), .fetch_word(fetch_word),
		.fetch_ready(fetch_ready), .mem_rd_data(mem_rd_data),
		.mem(mem), .working_reg(working_reg),
		.bank_select_reg(bank_select_reg), .flag_n(flag_n),
		.flag_z(flag_z), .bad_op(bad_op));

	// memory answers within the clock of the read strobe
	assign mem_rd_data = dmem[mem.addr];
	always @(posedge clock) begin
		if (mem.rd_en) begin
			n_rd <= n_rd + 1;
		end
		if (mem.wr_en) begin
			n_wr <= n_wr + 1;
			wa <= mem.addr;
			wd <= mem.wr_data;
			dmem[mem.addr] <= mem.wr_data;
		end
	end

	initial begin
		forever #2.5 clock = ~clock;
	end

	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : end_sim

	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// ready is a one-clock window, so poll it a bounded number of clocks
	task automatic issue(input logic [15:0] w);
		int n = 0;
		while (fetch_ready !== 1'b1 && n < 20) begin
			@(posedge clock);
			#1;
			n++;
		end
		fetch_valid = 1;
		fetch_word = w;
		@(posedge clock);
		#1;
		fetch_valid = 0;
	endtask : issue

	task automatic settle();
		repeat (4) @(posedge clock);
		#1;
	endtask : settle

	task automatic t_lit();
		issue(16'h0e9c);
		issue(16'h01a3);
		settle();
		check("work", working_reg, 8'h9c);
		check("bank", bank_select_reg, 8'ha3);
		check("flags", {flag_n, flag_z}, 2'b00);
		$display("test lit done");
	endtask : t_lit

	task automatic t_fdest();
		issue(16'h5122);
		settle();
		check("work", working_reg, 8'h80);
		check("n z", {flag_n, flag_z}, 2'b10);
		issue(16'h5010);
		settle();
		check("work", working_reg, 8'h41);
		check("n z", {flag_n, flag_z}, 2'b00);
		issue(16'h5285);
		settle();
		check("wr addr", wa, 12'hf85);
		check("wr data", wd, 8'h00);
		check("n z", {flag_n, flag_z}, 2'b01);
		check("work kept", working_reg, 8'h41);
		$display("test fdest done");
	endtask : t_fdest

	task automatic t_ff();
		int rd0 = n_rd;
		issue(16'hc123);
		// second word a cycle late: the three-cycle case
		repeat (4) @(posedge clock);
		#1;
		issue(16'hfabc);
		settle();
		settle();
		check("dest", dmem[12'habc], 8'h33);
		check("reads", 16'(n_rd - rd0), 16'h0001);
		check("flags", {flag_n, flag_z}, 2'b01);
		issue(16'hc123);
		issue(16'hffe8);
		settle();
		settle();
		check("work", working_reg, 8'h33);
		issue(16'hcfe8);
		// a plain data byte, never a counter or stack byte
		issue(16'hf200);
		settle();
		settle();
		check("from work", dmem[12'h200], 8'h33);
		$display("test ff done");
	endtask : t_ff

	task automatic t_bad();
		int w0 = n_wr;
		issue(16'hc123);
		issue(16'h0e77);
		check("abort", bad_op, 1'b1);
		issue(16'h0d05);
		check("foreign", bad_op, 1'b1);
		settle();
		settle();
		check("writes", 16'(n_wr - w0), 16'h0000);
		check("work", working_reg, 8'h33);
		$display("test bad done");
	endtask : t_bad

	initial begin
		dmem[12'h322] = 8'h80;
		dmem[12'hf85] = 8'h00;
		dmem[12'h010] = 8'h41;
		dmem[12'h123] = 8'h33;
		repeat (16) @(posedge clock);
		#1;
		rst = 0;
		t_lit();
		t_fdest();
		t_ff();
		t_bad();
		end_sim();
	end

	initial begin
		#20000;
		n_mismatch++;
		end_sim();
	end
endmodule : tb_mvx_exec
